// file: hw/urbp_top.sv
/*
  Serial receiver with baud generators, parity, muting and APB registers.
  Assumes an APB master on pclk and a remote transmitter on rx_pin.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Break character handled as framing error.
// - Idle frame sets flag, optional interrupt.
// - Overrun keeps buffer, sets flag, optional interrupt.
// - Error flags clear by status then data.
// - Majority of samples eight to ten.
// - Start noise uses edge and samples.
// - Noise flag rises with ready flag.
// - False start discarded, noise kept hidden.
// - Missing stop bit sets framing flag.
// - Independent three-bit dividers per direction.
// - Nonzero fine prescaler multiplies the division.
// - Muted receiver sets no flags, interrupts.
// - Idle wake clears mute, no idle flag.
// - Address wake on set top data bit.
// - Frame length from word size only.
// - Parity even or odd over low bits.
// - Transmit parity replaces top data bit.
// - Parity failure sets flag, optional interrupt.
// - Address wake uses data bit, not parity.
// - Sampling clock resynchronised at start bit.
// - Ready flag set on buffer load.
module urbp_top (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line and processor mask.
  input  wire logic        rx_pin,
  input  wire logic        cpu_irq_mask,
  // Transmit word handoff and interrupt.
  output logic      [8:0]  tx_word,
  output logic             tx_load,
  output logic             tx_baud_tick,
  output logic             irq_req
);
  import urbp_pkg::*;

  urbp_ctrl_t     ctrl_ff;
  urbp_stat_t     stat_ff;
  urbp_stat_t     nxt_stat;
  urbp_rx_state_t state_ff;
  urbp_rx_state_t nxt_state;
  logic        mute_ff;
  logic [7:0]  baud_ff;
  logic [7:0]  txf_ff;
  logic [7:0]  rxf_ff;
  logic [8:0]  hold_ff;
  logic [8:0]  shreg_ff;
  logic [3:0]  idx_ff;
  logic [3:0]  bitcnt_ff;
  logic [1:0]  smp_ff;
  logic [2:0]  hist_ff;
  logic [7:0]  idlecnt_ff;
  logic        idle_arm_ff;
  logic        nf_acc_ff;
  logic        hid_nf_ff;
  logic        armed_ff;
  logic [31:0] prdata_ff;
  logic [8:0]  tx_word_ff;
  logic        tx_load_ff;
  logic        lvl;
  logic        rx_tick;

  ////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes with no wait state.
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire hit_st  = (paddr == OFS_STATUS);
  wire hit_dat = (paddr == OFS_DATA);
  wire hit_ctl = (paddr == OFS_CTRL);
  wire hit_bd  = (paddr == OFS_BAUD);
  wire hit_txf = (paddr == OFS_TX_FINE);
  wire hit_rxf = (paddr == OFS_RX_FINE);
  wire hit_any = hit_st | hit_dat | hit_ctl | hit_bd | hit_txf | hit_rxf;
  wire st_rd   = rd && hit_st;
  wire dat_rd  = rd && hit_dat;
  wire dat_wr  = wr && hit_dat;
  wire ctl_wr  = wr && hit_ctl;

  // Read data mux, captured in the setup cycle.
  wire [31:0] rd_mux =
    hit_st  ? {26'h0000000, stat_ff} :
    hit_dat ? {23'h000000, hold_ff} :
    hit_ctl ? {22'h000000, mute_ff, ctrl_ff} :
    hit_bd  ? {24'h000000, baud_ff} :
    hit_txf ? {24'h000000, txf_ff} :
    hit_rxf ? {24'h000000, rxf_ff} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;
  assign prdata  = prdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Line synchroniser and the two baud generators.
  urbp_rx_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (rx_pin),
    .level   (lvl)
  );

  // Edge of a start bit, seen on a sample tick after three high samples.
  wire start_edge = rx_tick && (state_ff == RX_HUNT) && ctrl_ff.rx_enable
                    && (hist_ff == 3'h7) && !lvl;

  urbp_baud_gen u_txbaud (
    .pclk    (pclk),
    .presetn (presetn),
    .pre_sel (baud_ff[PRE_LSB +: 2]),
    .div_sel (baud_ff[TXDIV_LSB +: 3]),
    .fine    (txf_ff),
    .restart (!ctrl_ff.tx_enable),
    .tick    (tx_baud_tick)
  );

  urbp_baud_gen u_rxbaud (
    .pclk    (pclk),
    .presetn (presetn),
    .pre_sel (baud_ff[PRE_LSB +: 2]),
    .div_sel (baud_ff[RXDIV_LSB +: 3]),
    .fine    (rxf_ff),
    .restart (start_edge || !ctrl_ff.rx_enable),
    .tick    (rx_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bit evaluation at the tenth sample.
  wire       busy   = (state_ff != RX_HUNT);
  wire       eval   = rx_tick && busy && (idx_ff == IDX_S10);
  wire       b_end  = rx_tick && busy && (idx_ff == IDX_LAST);
  wire [2:0] s3     = {lvl, smp_ff};
  wire       maj    = urbp_maj3(s3);
  wire       noisy  = (s3 != 3'h0) && (s3 != 3'h7);
  wire [3:0] nbits  = ctrl_ff.word9 ? 4'h9 : 4'h8;
  wire       e_win  = (idx_ff == IDX_E3) || (idx_ff == IDX_E5)
                      || (idx_ff == IDX_E7);
  wire       e_bad  = rx_tick && (state_ff == RX_START) && e_win && lvl;
  wire       f_start = eval && (state_ff == RX_START) && maj;
  wire       f_end   = eval && (state_ff == RX_STOP);

  wire [8:0] dword = ctrl_ff.word9 ? shreg_ff : {1'b0, shreg_ff[8:1]};
  wire       d_msb = ctrl_ff.parity_enable ?
                     (ctrl_ff.word9 ? dword[7] : dword[6]) :
                     (ctrl_ff.word9 ? dword[8] : dword[7]);
  wire       p_bad = ctrl_ff.parity_enable && (ctrl_ff.parity_odd_sel !=
                     urbp_xor(dword, ctrl_ff.word9 ? 9'h1FF : 9'h0FF));
  wire       wake_ok = !mute_ff || (ctrl_ff.wake_addr_sel && d_msb);
  wire       accept  = f_end && wake_ok;
  wire       nf_all  = nf_acc_ff || noisy || hid_nf_ff;
  wire       rdy_set = accept && !stat_ff.rx_ready_flag;
  wire       ovr_set = accept && stat_ff.rx_ready_flag;

  // Idle frame detection after a received character or after reset.
  wire [7:0] idle_tgt = ctrl_ff.word9 ? IDLE_TICKS9 : IDLE_TICKS8;
  wire       idle_evt = rx_tick && !busy && lvl && idle_arm_ff
                        && ctrl_ff.rx_enable
                        && (idlecnt_ff == idle_tgt - 8'h01);
  wire       wake_idle = idle_evt && mute_ff && !ctrl_ff.wake_addr_sel;

  ////////////////////////////////////////////////////////////////////////
  // Receive state machine.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RX_HUNT:  nxt_state = start_edge ? RX_START : RX_HUNT;
      RX_START: begin
        if (f_start) begin
          nxt_state = RX_HUNT;
        end else if (b_end) begin
          nxt_state = RX_DATA;
        end
      end
      RX_DATA:  nxt_state = (b_end && bitcnt_ff == nbits) ? RX_STOP
                            : RX_DATA;
      RX_STOP:  nxt_state = f_end ? RX_HUNT : RX_STOP;
      default:  nxt_state = RX_HUNT;
    endcase
    if (!ctrl_ff.rx_enable) begin
      nxt_state = RX_HUNT;
    end
  end

  // Status flags; a hardware set wins over the clear sequence.
  // clear by status then data
  wire clr = dat_rd && armed_ff;
  always_comb begin
    nxt_stat.rx_ready_flag    = rdy_set ||
                                (stat_ff.rx_ready_flag && !clr);
    nxt_stat.idle_flag        = (idle_evt && !mute_ff) ||
                                (stat_ff.idle_flag && !clr);
    nxt_stat.overrun_flag     = ovr_set ||
                                (stat_ff.overrun_flag && !clr);
    nxt_stat.noise_flag       = (rdy_set && nf_all) ||
                                (stat_ff.noise_flag && !clr);
    nxt_stat.framing_err_flag = (rdy_set && !maj) ||
                                (stat_ff.framing_err_flag && !clr);
    nxt_stat.parity_err_flag  = (rdy_set && p_bad) ||
                                (stat_ff.parity_err_flag && !clr);
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers; a write to the control word may set mute.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      mute_ff <= MUTE_RST;
      baud_ff <= BAUD_RST;
      txf_ff  <= FINE_RST;
      rxf_ff  <= FINE_RST;
    end else begin
      ctrl_ff <= ctl_wr ? urbp_ctrl_t'(pwdata[CTRL_W-1:0]) : ctrl_ff;
      mute_ff <= ctl_wr ? pwdata[MUTE_POS]
                        : mute_ff && !wake_idle && !(accept && mute_ff);
      baud_ff <= (wr && hit_bd)  ? pwdata[7:0] : baud_ff;
      txf_ff  <= (wr && hit_txf) ? pwdata[7:0] : txf_ff;
      rxf_ff  <= (wr && hit_rxf) ? pwdata[7:0] : rxf_ff;
    end
  end

  // Bus side state: read capture, clear arming, status and buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      armed_ff  <= 1'b0;
      stat_ff   <= '0;
      hold_ff   <= HOLD_RST;
    end else begin
      prdata_ff <= (psel && !penable) ? rd_mux : prdata_ff;
      armed_ff  <= st_rd || (armed_ff && !dat_rd);
      stat_ff   <= nxt_stat;
      hold_ff   <= rdy_set ? dword : hold_ff;
    end
  end

  wire [8:0] tw     = pwdata[8:0];
  wire       tpar   = ctrl_ff.parity_odd_sel ^
                      urbp_xor(tw, ctrl_ff.word9 ? 9'h0FF : 9'h07F);
  wire [8:0] tw_par = ctrl_ff.word9 ? {tpar, tw[7:0]}
                                    : {1'b0, tpar, tw[6:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_word_ff <= 9'h000;
      tx_load_ff <= 1'b0;
    end else begin
      tx_word_ff <= !dat_wr ? tx_word_ff :
                    ctrl_ff.parity_enable ? tw_par : tw;
      tx_load_ff <= dat_wr;
    end
  end
  assign tx_word = tx_word_ff;
  assign tx_load = tx_load_ff;

  ////////////////////////////////////////////////////////////////////////
  // Sampling datapath.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= RX_HUNT;
      idx_ff      <= 4'h0;
      smp_ff      <= 2'h0;
      hist_ff     <= 3'h0;
      bitcnt_ff   <= 4'h0;
      shreg_ff    <= 9'h000;
      nf_acc_ff   <= 1'b0;
      hid_nf_ff   <= 1'b0;
      idlecnt_ff  <= 8'h00;
      idle_arm_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      idx_ff      <= start_edge ? 4'h0 : (rx_tick ? idx_ff + 4'h1 : idx_ff);
      smp_ff[0]   <= (rx_tick && idx_ff == IDX_S8) ? lvl : smp_ff[0];
      smp_ff[1]   <= (rx_tick && idx_ff == IDX_S9) ? lvl : smp_ff[1];
      hist_ff     <= (f_end || f_start) ? {3{maj}} :
                     (rx_tick && !busy) ? {hist_ff[1:0], lvl} : hist_ff;
      bitcnt_ff   <= start_edge ? 4'h0 :
                     (eval && state_ff == RX_DATA) ? bitcnt_ff + 4'h1
                                                   : bitcnt_ff;
      shreg_ff    <= (eval && state_ff == RX_DATA) ? {maj, shreg_ff[8:1]}
                                                   : shreg_ff;
      nf_acc_ff   <= start_edge ? 1'b0 :
                     nf_acc_ff || e_bad ||
                     (eval && noisy && state_ff != RX_STOP);
      hid_nf_ff   <= f_start || (hid_nf_ff && !rdy_set);
      idlecnt_ff  <= (busy || !lvl) ? 8'h00 :
                     (rx_tick && idlecnt_ff != idle_tgt) ?
                     idlecnt_ff + 8'h01 : idlecnt_ff;
      idle_arm_ff <= f_end || (idle_arm_ff && !idle_evt);
    end
  end

  assign irq_req = !cpu_irq_mask && !mute_ff && (
      (ctrl_ff.rx_irq_en && (stat_ff.rx_ready_flag || stat_ff.overrun_flag))
    || (ctrl_ff.idle_irq_en && stat_ff.idle_flag)
    || (ctrl_ff.parity_irq_en && stat_ff.parity_err_flag));

  ////////////////////////////////////////////////////////////////////////
  // Checks on the receive and transmit behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_overrun_keeps_buf: assert property (
    ovr_set |=> stat_ff.overrun_flag && $stable(hold_ff)
  ) else $error("overrun lost buffer or flag");

  a_ready_on_load: assert property (
    rdy_set |=> stat_ff.rx_ready_flag && hold_ff == $past(dword)
  ) else $error("ready not set on buffer load");

  a_clear_sequence: assert property (
    st_rd ##2 (psel && !penable) ##1 (dat_rd && !rdy_set)
    |=> !stat_ff.rx_ready_flag
  ) else $error("flag survived clear sequence");

  a_mute_no_flags: assert property (
    mute_ff && !accept |=> !$rose(stat_ff.rx_ready_flag)
                         && !$rose(stat_ff.idle_flag)
  ) else $error("muted receiver set a flag");

  a_irq_masked: assert property (
    cpu_irq_mask || mute_ff |-> !irq_req
  ) else $error("interrupt leaked through mask");

  a_false_start: assert property (
    f_start |=> state_ff == RX_HUNT && hid_nf_ff
                && !$rose(stat_ff.rx_ready_flag)
  ) else $error("false start not discarded");

  a_resync_start: assert property (
    start_edge |=> state_ff == RX_START && idx_ff == 4'h0
  ) else $error("no resync at start bit");

  a_idle_wake: assert property (
    wake_idle && !ctl_wr |=> !mute_ff && !$rose(stat_ff.idle_flag)
  ) else $error("idle wake misbehaved");

  a_tx_parity: assert property (
    dat_wr && ctrl_ff.parity_enable && !ctrl_ff.word9 && !ctl_wr
    |=> (^tx_word_ff[7:0]) == ctrl_ff.parity_odd_sel
  ) else $error("transmit parity wrong");

  a_framing_set: assert property (
    rdy_set && !maj |=> stat_ff.framing_err_flag && stat_ff.rx_ready_flag
  ) else $error("framing flag not set");

endmodule

`default_nettype wire

// file: hw/urbp_pkg.sv
/*
  Package for the serial receiver block: register offsets, field
  positions, reset values, sampling counts, carrier types and helpers.
  Assumes a 32-bit APB register bus and a single 25 MHz clock.
*/
`default_nettype none

package urbp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses on the APB bus).
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_DATA    = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_BAUD    = 8'h0C;
  localparam logic [7:0] OFS_TX_FINE = 8'h10;
  localparam logic [7:0] OFS_RX_FINE = 8'h14;

  // Field positions.
  localparam int CTRL_W    = 9;
  localparam int MUTE_POS  = 9;
  localparam int PRE_LSB   = 0;
  localparam int TXDIV_LSB = 2;
  localparam int RXDIV_LSB = 5;

  // Reset values.
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic       MUTE_RST = 1'b0;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] FINE_RST = 8'h00;
  localparam logic [8:0] HOLD_RST = 9'h000;

  // Sample indices within a bit (index 0 is the first of sixteen).
  localparam logic [3:0] IDX_S8   = 4'h7;
  localparam logic [3:0] IDX_S9   = 4'h8;
  localparam logic [3:0] IDX_S10  = 4'h9;
  localparam logic [3:0] IDX_E3   = 4'h2;
  localparam logic [3:0] IDX_E5   = 4'h4;
  localparam logic [3:0] IDX_E7   = 4'h6;
  localparam logic [3:0] IDX_LAST = 4'hF;

  // Samples in one idle frame of 10 or 11 bit times.
  localparam logic [7:0] IDLE_TICKS8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS9 = 8'hB0;

  ////////////////////////////////////////////////////////////////////////
  // Control register layout, top bit first, word9 at bit 0.
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic idle_irq_en;
    logic rx_irq_en;
    logic parity_irq_en;
    logic wake_addr_sel;
    logic parity_odd_sel;
    logic parity_enable;
    logic word9;
  } urbp_ctrl_t;

  // Status register layout, top bit first, parity_err_flag at bit 0.
  typedef struct packed {
    logic rx_ready_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_err_flag;
    logic parity_err_flag;
  } urbp_stat_t;

  typedef enum logic [3:0] {
    RX_HUNT  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } urbp_rx_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Majority of three samples.
  function automatic logic urbp_maj3(input logic [2:0] s);
    urbp_maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Exclusive-or of the bits of a word selected by a mask.
  function automatic logic urbp_xor(input logic [8:0] w,
                                    input logic [8:0] m);
    urbp_xor = ^(w & m);
  endfunction

  // Clock cycles per sample tick from prescale, divider and fine value.
  function automatic logic [18:0] urbp_divisor(input logic [1:0] pre,
                                               input logic [2:0] dsel,
                                               input logic [7:0] fine);
    logic [18:0] pr;
    logic [18:0] base;
    case (pre)
      2'h0:    pr = 19'h00001;
      2'h1:    pr = 19'h00003;
      2'h2:    pr = 19'h00004;
      default: pr = 19'h0000D;
    endcase
    base = pr << dsel;
    urbp_divisor = (fine == 8'h00) ? base : 19'(base * {11'h000, fine});
  endfunction

endpackage

`default_nettype wire

// file: hw/urbp_baud_gen.sv
/*
  Baud generator: one-cycle tick at sixteen times the bit rate.
  Assumes settings stay still while the direction is enabled.
*/
`timescale 1ns/1ps
`default_nettype none

module urbp_baud_gen (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Rate settings and restart.
  input  wire logic [1:0] pre_sel,
  input  wire logic [2:0] div_sel,
  input  wire logic [7:0] fine,
  input  wire logic       restart,
  // Sample tick.
  output logic            tick
);
  import urbp_pkg::*;

  logic [18:0] cnt_ff;
  logic        tick_ff;
  logic [18:0] limit;
  logic        wrap;

  // Count limit and wrap decode.
  assign limit = urbp_divisor(pre_sel, div_sel, fine) - 19'h00001;
  assign wrap  = (cnt_ff >= limit);
  assign tick  = tick_ff;

  // Cycle counter; a restart realigns the sample phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 19'h00000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= (restart || wrap) ? 19'h00000 : cnt_ff + 19'h00001;
      tick_ff <= wrap && !restart;
    end
  end
endmodule

`default_nettype wire

// file: hw/urbp_rx_sync.sv
/*
  Receive pin synchroniser with a two-sample agreement filter.
  Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module urbp_rx_sync (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw pin and filtered level.
  input  wire logic pin,
  output logic      level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  assign level = level_ff;

  // Three stages; the level moves only when stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff    <= 1'b1;
      s2_ff    <= 1'b1;
      s3_ff    <= 1'b1;
      level_ff <= 1'b1;
    end else begin
      s1_ff    <= pin;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= (s2_ff == s3_ff) ? s3_ff : level_ff;
    end
  end
endmodule

`default_nettype wire

// file: verif/urbp_line_model.sv
/*
  Remote serial transmitter that drives the receive line of the block.
  Assumes the bench calls its tasks and that the line idles high.
*/
`timescale 1ns/1ps
`default_nettype none

module urbp_line_model (
  // Clock.
  input  wire logic pclk,
  // Serial line.
  output logic      line
);
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Sends start, nb data bits LSB first and stop; cps clocks per sample.
  task automatic send(input logic [8:0] w, input int nb,
                      input logic stp, input int cps);
    int i;
    for (i = 0; i < nb + 2; i++) begin
      repeat (16 * cps) @(posedge pclk)
        line <= (i == 0) ? 1'b0 : (i == nb + 1) ? stp : w[i - 1];
    end
    @(posedge pclk) line <= 1'b1;
  endtask

  // Short low pulse that looks like a start edge but is not one.
  task automatic glitch(input int n);
    repeat (n) @(posedge pclk) line <= 1'b0;
    @(posedge pclk) line <= 1'b1;
  endtask
endmodule

`default_nettype wire

// file: verif/uart_receiver_baud_parity_tb.sv
/*
  Self-checking bench for the serial receiver, driven over APB.
  Assumes the line model above and the register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none

module uart_receiver_baud_parity_tb;
  import urbp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, cpu_irq_mask;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, tx_load, tx_baud_tick, irq_req;
  logic [8:0]  tx_word;
  wire logic   rx_line;
  int          error_cnt, total_checks, cps, k;
  logic [8:0]  d, e;
  logic        perr;

  urbp_line_model line_m (.pclk(pclk), .line(rx_line));
  urbp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_line),
    .cpu_irq_mask(cpu_irq_mask), .tx_word(tx_word), .tx_load(tx_load),
    .tx_baud_tick(tx_baud_tick), .irq_req(irq_req));

  ////////////////////////////////////////////////////////////////////////
  // Clock at 40 ns period.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compares a seen value with the expected one.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; reads are compared, error response always.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           input logic [31:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check({31'h0, pready}, 1);
    if (!w) check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, a > OFS_RX_FINE});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits past the idle frame, then status, data and cleared status.
  task rx_chk(input logic [31:0] st, input logic [8:0] dat);
    repeat (200 * cps) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 0, st);
    apb(1'b0, OFS_DATA, 0, {23'h0, dat});
    apb(1'b0, OFS_STATUS, 0, 0);
  endtask

  // Prints the verdict and ends the run.
  task results;
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hung wait.
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; cpu_irq_mask = 1'b0;
    error_cnt = 0; total_checks = 0; cps = 1;
    void'($urandom(57309));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 0, 0);
    apb(1'b0, 8'h20, 0, 0);
    apb(1'b1, OFS_BAUD, 0, 0);
    apb(1'b1, OFS_CTRL, 32'h0A0, 0);
    d = 9'($urandom) & 9'h0FF;
    line_m.send(d, 8, 1'b1, cps);
    repeat (10) @(posedge pclk);
    check({31'h0, irq_req}, 1);
    check({31'h0, tx_baud_tick}, 0);
    cpu_irq_mask <= 1'b1;
    repeat (2) @(posedge pclk);
    check({31'h0, irq_req}, 0);
    cpu_irq_mask <= 1'b0;
    rx_chk(32'h30, d);
    e = 9'($urandom) & 9'h0FF;
    line_m.send(d, 8, 1'b1, cps);
    line_m.send(e, 8, 1'b1, cps);
    rx_chk(32'h38, d);
    line_m.send(9'h000, 8, 1'b0, cps);
    rx_chk(32'h32, 9'h000);
    line_m.glitch(4);
    repeat (20) @(posedge pclk);
    line_m.send(d, 8, 1'b1, cps);
    rx_chk(32'h34, d);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, OFS_CTRL, 32'h0A2 | ((k & 1) << 2), 0);
      d = 9'($urandom) & 9'h0FF;
      perr = (^d[7:0]) != k[0];
      line_m.send(d, 8, 1'b1, cps);
      rx_chk(32'h30 | perr, d);
      apb(1'b1, OFS_DATA, d, 0);
      @(negedge pclk);
      check({31'h0, tx_load}, 1);
      repeat (2) @(posedge pclk);
      check(tx_word, {2'b00, ^d[6:0] ^ k[0], d[6:0]});
    end
    apb(1'b1, OFS_CTRL, 32'h081, 0);
    d = 9'($urandom);
    line_m.send(d, 9, 1'b1, cps);
    rx_chk(32'h30, d);
    apb(1'b1, OFS_CTRL, 0, 0);
    apb(1'b1, OFS_RX_FINE, 3, 0);
    apb(1'b1, OFS_CTRL, 32'h288, 0);
    cps = 3;
    line_m.send(9'h012, 8, 1'b1, cps);
    repeat (200 * cps) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 0, 0);
    line_m.send(9'h095, 8, 1'b1, cps);
    rx_chk(32'h30, 9'h095);
    apb(1'b0, OFS_CTRL, 0, 32'h088);
    results;
  end
endmodule

`default_nettype wire
